// >>> design/vsr_pkg.sv
// shared constants, field layout and helpers of the vibration status readout block
`default_nettype none
package vsr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_COUNT     = 8'h0A;
    localparam logic [ADDR_W-1:0] REG_DIAG      = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_TEMP_WIDE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_ST_XV     = 8'h2A;
    localparam logic [ADDR_W-1:0] REG_ST_ZY     = 8'h2C;
    localparam logic [ADDR_W-1:0] REG_TEMP_CS   = 8'h2E;
    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h40;

    // control register bits
    localparam int CTRL_W        = 6;
    localparam int CTRL_TEMP_SEL = 0;
    localparam int CTRL_BURST    = 1;
    localparam int CTRL_DISP     = 2;
    localparam int CTRL_RMS      = 3;
    localparam int CTRL_RUN      = 4;
    localparam int CTRL_NORMAL   = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // field positions
    localparam int DIAG_X_LSB  = 8;
    localparam int DIAG_Y_LSB  = 10;
    localparam int DIAG_Z_LSB  = 12;
    localparam int CS_ALM_LSB  = 2;
    localparam int CS_RES_LSB  = 5;
    localparam int CS_TEMP_LSB = 8;
    localparam int BYTE_HI_LSB = 8;

    // resonance level codes
    localparam logic [1:0] RES_OK    = 2'h0;
    localparam logic [1:0] RES_LARGE = 2'h1;

    // sample count timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int VEL_COUNT_NS  = 167000;
    localparam int DISP_COUNT_NS = 1670000;
    localparam int VEL_COUNT_CYC  = VEL_COUNT_NS / CLK_PERIOD_NS;
    localparam int DISP_COUNT_CYC = DISP_COUNT_NS / CLK_PERIOD_NS;
    localparam logic [15:0] RAW_STEP   = 16'h0002;
    localparam logic [15:0] RMS_PERIOD = 16'h1770;
    localparam logic [15:0] RMS_OFFSET = 16'h0002;

    // self-test data: raw input in 0.25 m/s2 steps
    localparam int ST_RAW_W = 10;
    localparam logic [7:0] ST_POS_SAT = 8'h7F;
    localparam logic [7:0] ST_NEG_SAT = 8'h81;

    typedef enum logic [1:0] {
        VSR_TM_IDLE = 2'b01,
        VSR_TM_RUN  = 2'b10
    } vsr_tm_e;

    // clamp to the 8-bit readout range, symmetric around zero
    function automatic logic [7:0] vsr_sat8(input logic signed [ST_RAW_W-1:0] v);
        logic signed [ST_RAW_W-1:0] hi;
        logic signed [ST_RAW_W-1:0] lo;
        hi = ST_RAW_W'(signed'({1'b0, ST_POS_SAT}));
        lo = -hi;
        if (v >= hi)
            return ST_POS_SAT;
        else if (v <= lo)
            return ST_NEG_SAT;
        else
            return v[7:0];
    endfunction
endpackage
`default_nettype wire

// >>> design/vsr_sample_if.sv
// sample counter signals passed from the timer to the register block
`default_nettype none
interface vsr_sample_if;
    logic [15:0] count;
    logic        report;
    logic [1:0]  two_bit;
    modport src (output count, output report, output two_bit);
    modport dst (input count, input report, input two_bit);
endinterface
`default_nettype wire

// >>> design/vsr_sample_timer.sv
// front-end sampling tick, sample count and report strobe
`default_nettype none
module vsr_sample_timer
    import vsr_pkg::*;
#(
    parameter int VEL_CYC  = VEL_COUNT_CYC,
    parameter int DISP_CYC = DISP_COUNT_CYC
) (
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    input  wire logic run_in,
    input  wire logic disp_in,
    input  wire logic rms_in,
    vsr_sample_if.src sif
);
    vsr_tm_e     state;
    logic [31:0] pre;
    logic        tick;
    logic [15:0] cnt;
    logic [15:0] rms_acc;
    logic        report;
    logic [1:0]  two_bit;
    logic [15:0] next_cnt;

    // one tick per front-end sample period, chosen by quantity
    assign tick = (state == VSR_TM_RUN) &&
                  (pre == 32'(disp_in ? DISP_CYC - 1 : VEL_CYC - 1));
    assign next_cnt = cnt + 16'h0001;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            state <= VSR_TM_IDLE;
        else begin
            case (state)
                VSR_TM_IDLE: if (run_in) state <= VSR_TM_RUN;
                VSR_TM_RUN:  if (!run_in) state <= VSR_TM_IDLE;
                default:     state <= VSR_TM_IDLE;
            endcase
        end
    end

    // prescaler restarts whenever sampling stops
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            pre <= '0;
        else if (state != VSR_TM_RUN || tick)
            pre <= '0;
        else
            pre <= pre + 32'h0000_0001;
    end

    // count wraps naturally at 16 bits: ..., 65534, 65535, 0, 1
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt     <= '0;
            rms_acc <= '0;
            report  <= 1'b0;
        end else if (state != VSR_TM_RUN) begin
            cnt     <= '0;
            rms_acc <= '0;
            report  <= 1'b0;
        end else if (tick) begin
            cnt <= next_cnt;
            if (rms_in) begin
                // first report at 6002, then every 6000 counts
                report  <= (rms_acc + 16'h0001) == (RMS_PERIOD + RMS_OFFSET);
                rms_acc <= ((rms_acc + 16'h0001) == (RMS_PERIOD + RMS_OFFSET)) ?
                           RMS_OFFSET : rms_acc + 16'h0001;
            end else begin
                report  <= (next_cnt & (RAW_STEP - 16'h0001)) == 16'h0000;
                rms_acc <= '0;
            end
        end else
            report <= 1'b0;
    end

    // two-bit counter steps on each reported sample and wraps 3 to 0
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            two_bit <= '0;
        else if (report)
            two_bit <= two_bit + 2'h1;
    end

    assign sif.count   = cnt;
    assign sif.report  = report;
    assign sif.two_bit = two_bit;
endmodule
`default_nettype wire

// >>> design/vsr_status_regs.sv
// readout and status registers of the three-axis vibration sensor
`default_nettype none
module vsr_status_regs
    import vsr_pkg::*;
#(
    parameter int VEL_CYC  = VEL_COUNT_CYC,
    parameter int DISP_CYC = DISP_COUNT_CYC
) (
    input  wire logic                       core_clk_in,
    input  wire logic                       rstn_in,
    input  wire logic [ADDR_W-1:0]          reg_addr_in,
    input  wire logic [DATA_W-1:0]          reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [DATA_W-1:0]          reg_rdata_out,
    input  wire logic                       temp_valid_in,
    input  wire logic [15:0]                temp_value_in,
    input  wire logic                       diag_done_in,
    input  wire logic [5:0]                 diag_level_in,
    input  wire logic                       selftest_done_in,
    input  wire logic signed [ST_RAW_W-1:0] st_x_in,
    input  wire logic signed [ST_RAW_W-1:0] st_y_in,
    input  wire logic signed [ST_RAW_W-1:0] st_z_in,
    input  wire logic signed [ST_RAW_W-1:0] st_vec_in,
    input  wire logic [2:0]                 resonance_event_in,
    input  wire logic [2:0]                 alarm_event_in,
    input  wire logic                       main_flag_read_in,
    output logic      [2:0]                 main_resonance_flags_out,
    output logic                            range_limit_out,
    output logic      [15:0]                burst_word_out,
    output logic                            burst_valid_out
);
    vsr_sample_if sif ();

    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       sample_counter;
    logic [1:0]        x_resonance_level;
    logic [1:0]        y_resonance_level;
    logic [1:0]        z_resonance_level;
    logic [15:0]       temp_value_wide;
    logic [7:0]        temp_value_narrow;
    logic [7:0]        selftest_x_accel;
    logic [7:0]        selftest_y_accel;
    logic [7:0]        selftest_z_accel;
    logic [7:0]        selftest_vector_magnitude;
    logic [2:0]        resonance_error_flags;
    logic [2:0]        threshold_alarm_flags;
    logic [2:0]        main_res_flags;
    logic [15:0]       resonance_diag_status;
    logic [15:0]       temperature_compact_status;
    logic              rd_diag;
    logic              rd_cs;
    logic              burst_out;
    logic              clr_cs;
    logic [DATA_W-1:0] next_rdata;

    // sampling tick and sample count run in their own module
    vsr_sample_timer #(
        .VEL_CYC  (VEL_CYC),
        .DISP_CYC (DISP_CYC)
    ) u_timer (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .run_in      (ctrl[CTRL_RUN]),
        .disp_in     (ctrl[CTRL_DISP]),
        .rms_in      (ctrl[CTRL_RMS]),
        .sif         (sif)
    );

    // read and burst strobes that carry side effects
    assign rd_diag   = reg_rd_in && (reg_addr_in == REG_DIAG);
    assign rd_cs     = reg_rd_in && (reg_addr_in == REG_TEMP_CS);
    assign burst_out = ctrl[CTRL_BURST] && sif.report;
    assign clr_cs    = rd_cs || burst_out;

    // control register: the only writable word
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            ctrl <= CTRL_RST;
        else if (reg_wr_in && reg_addr_in == REG_CTRL)
            ctrl <= reg_wdata_in[CTRL_W-1:0];
    end

    // reported count is latched on each output sample
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            sample_counter <= '0;
        else if (sif.report)
            sample_counter <= sif.count;
    end

    // resonance level results; a fresh result beats a clearing read
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            x_resonance_level <= RES_OK;
            y_resonance_level <= RES_OK;
            z_resonance_level <= RES_OK;
        end else if (diag_done_in) begin
            z_resonance_level <= diag_level_in[5:4];
            y_resonance_level <= diag_level_in[3:2];
            x_resonance_level <= diag_level_in[1:0];
        end else if (rd_diag) begin
            x_resonance_level <= RES_OK;
            y_resonance_level <= RES_OK;
            z_resonance_level <= RES_OK;
        end
    end

    // temperature: the compact byte is the top of the wide word
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            temp_value_wide   <= '0;
            temp_value_narrow <= '0;
        end else if (temp_valid_in) begin
            temp_value_wide   <= temp_value_in;
            temp_value_narrow <= temp_value_in[15:BYTE_HI_LSB];
        end
    end

    // self-test results, clamped so an overrange never wraps sign
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            selftest_x_accel          <= '0;
            selftest_y_accel          <= '0;
            selftest_z_accel          <= '0;
            selftest_vector_magnitude <= '0;
        end else if (selftest_done_in) begin
            selftest_x_accel          <= vsr_sat8(st_x_in);
            selftest_y_accel          <= vsr_sat8(st_y_in);
            selftest_z_accel          <= vsr_sat8(st_z_in);
            selftest_vector_magnitude <= vsr_sat8(st_vec_in);
        end
    end

    // compact flags: sticky, cleared by read or burst output, set wins
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            resonance_error_flags <= '0;
            threshold_alarm_flags <= '0;
        end else begin
            resonance_error_flags <= (clr_cs ? 3'h0 : resonance_error_flags)
                                     | resonance_event_in;
            threshold_alarm_flags <= (clr_cs ? 3'h0 : threshold_alarm_flags)
                                     | alarm_event_in;
        end
    end

    // main-flag copy of resonance errors, cleared only by its own read
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            main_res_flags <= '0;
        else
            main_res_flags <= (main_flag_read_in ? 3'h0 : main_res_flags)
                              | resonance_event_in;
    end

    assign main_resonance_flags_out = main_res_flags;

    // normal mode substitutes the range limit while a warning is unread
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            range_limit_out <= 1'b0;
        else
            range_limit_out <= ctrl[CTRL_NORMAL] &&
                               (|((main_flag_read_in ? 3'h0 : main_res_flags) | resonance_event_in));
    end

    // assembled register words
    always_comb begin
        resonance_diag_status = '0;
        resonance_diag_status[DIAG_Z_LSB +: 2] = z_resonance_level;
        resonance_diag_status[DIAG_Y_LSB +: 2] = y_resonance_level;
        resonance_diag_status[DIAG_X_LSB +: 2] = x_resonance_level;
    end

    always_comb begin
        temperature_compact_status = '0;
        temperature_compact_status[CS_TEMP_LSB +: 8] = temp_value_narrow;
        temperature_compact_status[CS_RES_LSB +: 3]  = resonance_error_flags;
        temperature_compact_status[CS_ALM_LSB +: 3]  = threshold_alarm_flags;
        temperature_compact_status[1:0]              = sif.two_bit;
    end

    // burst word captures the flags, or the wide temperature when selected, before the same-cycle clear
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            burst_word_out  <= '0;
            burst_valid_out <= 1'b0;
        end else begin
            burst_valid_out <= burst_out;
            if (burst_out)
                burst_word_out <= ctrl[CTRL_TEMP_SEL] ? temp_value_wide
                                                      : temperature_compact_status;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        case (reg_addr_in)
            REG_COUNT:     next_rdata = sample_counter;
            REG_DIAG:      next_rdata = resonance_diag_status;
            REG_TEMP_WIDE: next_rdata = temp_value_wide;
            REG_ST_XV:     next_rdata = {selftest_x_accel, selftest_vector_magnitude};
            REG_ST_ZY:     next_rdata = {selftest_z_accel, selftest_y_accel};
            REG_TEMP_CS:   next_rdata = temperature_compact_status;
            REG_CTRL:      next_rdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
            default:       next_rdata = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            reg_rdata_out <= '0;
        else if (reg_rd_in)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= '0;
    end
endmodule
`default_nettype wire

// >>> tb/vsr_monitor.sv
// concurrent checks on the ports of the status readout block
`default_nettype none
module vsr_monitor
    import vsr_pkg::*;
(
    input  wire logic                       core_clk_in,
    input  wire logic                       rstn_in,
    input  wire logic [ADDR_W-1:0]          reg_addr_in,
    input  wire logic                       reg_rd_in,
    input  wire logic [DATA_W-1:0]          reg_rdata_out,
    input  wire logic                       temp_valid_in,
    input  wire logic [15:0]                temp_value_in,
    input  wire logic                       diag_done_in,
    input  wire logic                       selftest_done_in,
    input  wire logic signed [ST_RAW_W-1:0] st_x_in,
    input  wire logic [2:0]                 resonance_event_in,
    input  wire logic [2:0]                 alarm_event_in,
    input  wire logic                       main_flag_read_in,
    input  wire logic [2:0]                 main_resonance_flags_out,
    input  wire logic                       range_limit_out,
    input  wire logic                       burst_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // no set source active, so a clear cannot be masked by set-wins
    sequence quiet;
        resonance_event_in == 3'h0 && alarm_event_in == 3'h0 && !diag_done_in;
    endsequence
    sequence rd_of(logic [ADDR_W-1:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside answer cycle");
    // first read clears, a second read three cycles on must see nothing
    a_compact_clear: assert property ((rd_of(REG_TEMP_CS) and quiet) ##1 quiet [*2]
        ##1 rd_of(REG_TEMP_CS) |=> reg_rdata_out[7:2] == 6'h00)
        else $error("compact flags survived a read");
    a_diag_clear: assert property ((rd_of(REG_DIAG) and quiet) ##1 quiet [*2]
        ##1 rd_of(REG_DIAG) |=> reg_rdata_out[13:8] == 6'h00)
        else $error("diagnosis levels survived a read");
    a_burst_pulse: assert property (burst_valid_out |=> !burst_valid_out)
        else $error("burst valid longer than one cycle");
    a_main_set: assert property (resonance_event_in != 3'h0
        |=> (main_resonance_flags_out & $past(resonance_event_in)) == $past(resonance_event_in))
        else $error("main resonance flag not set");
    a_main_clear: assert property (main_flag_read_in && resonance_event_in == 3'h0
        |=> main_resonance_flags_out == 3'h0) else $error("main flags not cleared by read");
    a_limit_off: assert property (main_resonance_flags_out == 3'h0 && resonance_event_in == 3'h0
        |=> !range_limit_out) else $error("range limit without resonance");
    a_temp_wide: assert property (temp_valid_in ##1 !temp_valid_in
        ##1 (rd_of(REG_TEMP_WIDE) and !temp_valid_in) |=> reg_rdata_out == $past(temp_value_in, 3))
        else $error("wide temperature mismatch");
    a_sat_pos: assert property (selftest_done_in && st_x_in >= 127 ##1 !selftest_done_in
        ##1 (rd_of(REG_ST_XV) and !selftest_done_in) |=> reg_rdata_out[15:8] == ST_POS_SAT)
        else $error("positive self-test value not saturated");
endmodule
`default_nettype wire

// >>> tb/vsr_host_model.sv
// host master model for the register port
`default_nettype none
module vsr_host_model
    import vsr_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic [DATA_W-1:0] rdata_in,
    output var  logic [ADDR_W-1:0] addr_out,
    output var  logic [DATA_W-1:0] wdata_out,
    output var  logic              wr_out,
    output var  logic              rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_out = 8'h00;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // released lines show the inverse, so stale values are never trusted
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge core_clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge core_clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(posedge core_clk_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the status readout registers
`default_nettype none
module testbench
    import vsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0]  x, y, z, v;
        logic [15:0] xv, zy, tmp;
        logic [5:0]  lvl;
    } vsr_row_s;
    logic                       clk = 1'b0;
    logic                       rstn = 1'b0;
    logic [ADDR_W-1:0]          addr;
    logic [DATA_W-1:0]          wdata, rdata, burst_word, cnt0, w0;
    logic                       wr, rd, limit, burst_valid;
    logic                       temp_valid = 1'b0, diag_done = 1'b0, st_done = 1'b0, main_rd = 1'b0;
    logic [15:0]                temp_value = 16'h0000;
    logic [5:0]                 diag_level = 6'h00;
    logic signed [ST_RAW_W-1:0] st_x = '0, st_y = '0, st_z = '0, st_v = '0;
    logic [2:0]                 res_ev = 3'h0, alm_ev = 3'h0, main_flags;
    int                         failures = 0, checked = 0;
    // saturation edges on both sides, every level code
    vsr_row_s rows [4] = '{
        '{10'h07F, 10'h381, 10'h005, 10'h0C8, 16'h7F7F, 16'h0581, 16'h7FFF, 6'h01},
        '{10'h07E, 10'h382, 10'h3FF, 10'h2D4, 16'h7E81, 16'hFF82, 16'h8000, 6'h04},
        '{10'h000, 10'h001, 10'h1FF, 10'h200, 16'h0081, 16'h7F01, 16'h0000, 6'h10},
        '{10'h380, 10'h3FF, 10'h3FE, 10'h001, 16'h8101, 16'hFEFF, 16'hFF12, 6'h15}};

    vsr_host_model vsr_host_model_inst (.core_clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    // short tick periods keep the long sample counts affordable
    vsr_status_regs #(.VEL_CYC(4), .DISP_CYC(8)) vsr_status_regs_inst (.core_clk_in(clk), .rstn_in(rstn),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .temp_valid_in(temp_valid), .temp_value_in(temp_value), .diag_done_in(diag_done),
        .diag_level_in(diag_level), .selftest_done_in(st_done), .st_x_in(st_x), .st_y_in(st_y),
        .st_z_in(st_z), .st_vec_in(st_v), .resonance_event_in(res_ev), .alarm_event_in(alm_ev),
        .main_flag_read_in(main_rd), .main_resonance_flags_out(main_flags), .range_limit_out(limit),
        .burst_word_out(burst_word), .burst_valid_out(burst_valid));

    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
        logic [15:0] d;
        vsr_host_model_inst.rd(a, d);
        check(d & m, exp);
    endtask
    // bounded wait for the next burst pulse; a miss counts as a mismatch
    task automatic wait_burst(input int lim);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (burst_valid !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n >= lim), 16'h0000);
    endtask
    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (70000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check(rdata | burst_word | {13'h0, main_flags}, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk);
            {st_x, st_y, st_z, st_v} <= {rows[i].x, rows[i].y, rows[i].z, rows[i].v};
            {diag_level, temp_value} <= {rows[i].lvl, rows[i].tmp};
            {st_done, diag_done} <= 2'b11;
            @(posedge clk);
            {st_done, diag_done} <= 2'b00;
            rd_check(REG_ST_XV, rows[i].xv, 16'hFFFF);
            rd_check(REG_ST_ZY, rows[i].zy, 16'hFFFF);
            rd_check(REG_DIAG, {2'h0, rows[i].lvl, 8'h00}, 16'hFFFF);
            rd_check(REG_DIAG, 16'h0000, 16'hFFFF);
            @(posedge clk);
            temp_valid <= 1'b1;
            @(posedge clk);
            temp_valid <= 1'b0;
            rd_check(REG_TEMP_WIDE, rows[i].tmp, 16'hFFFF);
            rd_check(REG_TEMP_CS, rows[i].tmp & 16'hFF00, 16'hFF00);
        end
        // awkward cases: flag pair, read-only write, unmapped read
        @(posedge clk);
        {res_ev, alm_ev} <= {3'h5, 3'h2};
        @(posedge clk);
        {res_ev, alm_ev} <= 6'h00;
        rd_check(REG_TEMP_CS, 16'h00A8, 16'h00FC);
        rd_check(REG_TEMP_CS, 16'h0000, 16'h00FC);
        vsr_host_model_inst.wr(REG_CTRL, 16'h0020);
        repeat (2) @(posedge clk);
        #1;
        check({12'h0, limit, main_flags}, 16'h000D);
        @(posedge clk);
        main_rd <= 1'b1;
        @(posedge clk);
        main_rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({12'h0, limit, main_flags}, 16'h0000);
        vsr_host_model_inst.wr(REG_TEMP_WIDE, 16'h1234);
        rd_check(REG_TEMP_WIDE, 16'hFF12, 16'hFFFF);
        rd_check(8'h3C, 16'h0000, 16'hFFFF);
        // rms output from a fresh count
        vsr_host_model_inst.wr(REG_CTRL, 16'h001A);
        for (int k = 1; k <= 2; k++) begin
            wait_burst(30000);
            rd_check(REG_COUNT, 16'(6000 * k + 2), 16'hFFFF);
        end
        // raw output: steps of two, two-bit counter wraps
        vsr_host_model_inst.wr(REG_CTRL, 16'h0012);
        wait_burst(100);
        vsr_host_model_inst.rd(REG_COUNT, cnt0);
        w0 = burst_word;
        for (int k = 0; k < 5; k++) begin
            wait_burst(100);
            check(burst_word & 16'h0003, (w0 + 16'h0001) & 16'h0003);
            rd_check(REG_COUNT, cnt0 + 16'h0002, 16'hFFFF);
            cnt0 = cnt0 + 16'h0002;
            w0 = burst_word;
        end
        @(posedge clk);
        alm_ev <= 3'h7;
        @(posedge clk);
        alm_ev <= 3'h0;
        wait_burst(100);
        check(burst_word & 16'h001C, 16'h001C);
        rd_check(REG_TEMP_CS, 16'h0000, 16'h00FC);
        vsr_host_model_inst.wr(REG_CTRL, 16'h0013);
        wait_burst(100);
        check(burst_word, 16'hFF12);
        rd_check(REG_CTRL, 16'h0013, 16'hFFFF);
        // displacement ticks: one raw report every two long ticks
        vsr_host_model_inst.wr(REG_CTRL, 16'h0017);
        wait_burst(100);
        repeat (15) @(posedge clk);
        #1;
        check({15'h0, burst_valid}, 16'h0000);
        @(posedge clk);
        #1;
        check({15'h0, burst_valid}, 16'h0001);
        // mid-run reset clears the control word and the count
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_check(REG_CTRL, 16'h0000, 16'hFFFF);
        rd_check(REG_COUNT, 16'h0000, 16'hFFFF);
        finish_test();
    end
endmodule
bind vsr_status_regs vsr_monitor vsr_monitor_inst (.core_clk_in, .rstn_in, .reg_addr_in, .reg_rd_in,
    .reg_rdata_out, .temp_valid_in, .temp_value_in, .diag_done_in, .selftest_done_in, .st_x_in,
    .resonance_event_in, .alarm_event_in, .main_flag_read_in, .main_resonance_flags_out,
    .range_limit_out, .burst_valid_out);
`default_nettype wire
